//--- src/awu_pkg.sv
package awu_pkg;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] PORTA_OFF = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFF = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h10;
    // Control register fields
    localparam int CTRL_IE_BIT = 0;
    localparam int CTRL_RATE_BIT = 1;
    localparam int CTRL_KMASK_BIT = 2;
    localparam int CTRL_ACK_BIT = 3;
    // Status register fields
    localparam int STAT_LATCH_BIT = 0;
    localparam int STAT_RUN_BIT = 1;
    localparam int STAT_IRQ_BIT = 2;
    // Port A data: latch read-back position
    localparam int PORTA_LATCH_BIT = 6;
    // Interrupt status / mask fields
    localparam int EV_WAKE_BIT = 0;
    localparam int EV_ENTRY_BIT = 1;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;
    localparam logic [7:0] PORTA_IN_MASK = 8'h3F;
    // Wakeup periods in microseconds and the RC oscillator rate
    localparam int LONG_PERIOD_US = 650000;
    localparam int SHORT_PERIOD_US = 16000;
    localparam int RC_TICK_NS = 1000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int RC_DIV = RC_TICK_NS / CLK_PERIOD_NS;
    localparam int LONG_TICKS = LONG_PERIOD_US * 1000 / RC_TICK_NS;
    localparam int SHORT_TICKS = SHORT_PERIOD_US * 1000 / RC_TICK_NS;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : awu_pkg

//--- src/awu_timer.sv
// Overview of operation
// RULE_01 - Entering stop with the wakeup enable set starts wakeup generation.
// RULE_02 - The wakeup oscillator and counters idle outside stop mode.
// RULE_03 - Wait mode keeps the unit inactive and raises no request.
// RULE_04 - The counters are cleared to zero on every stop entry.
// RULE_05 - On overflow a wakeup request is latched and sent to keyboard logic.
// RULE_06 - Rate select clear gives the 650 ms period, set gives 16 ms.
// RULE_07 - A high wakeup request with the enable set sets the latch.
// RULE_08 - A latched wakeup is serviced, on the keyboard vector, only if enabled.
// RULE_09 - The latch reads back read-only at bit 6 of port A data.
// RULE_10 - Port A bit 6 has no direction, data latch or pullup control.
// RULE_11 - Writing the keyboard acknowledge bit or any reset clears the latch.
// RULE_12 - The latch reads back whatever the wakeup enable bit is.
// RULE_13 - Software clears the keyboard mask before stop so wakeups can exit.
// RULE_14 - A dedicated oscillator, used for nothing else, clocks the generator.
// RULE_15 - The latch holds until acked or reset; request while enabled, unmasked.
`timescale 1ns/1ns
module awu_timer
    import awu_pkg::*;
#(
    parameter int LONG_COUNT = LONG_TICKS,   // Ticks for the long period
    parameter int SHORT_COUNT = SHORT_TICKS, // Ticks for the short period
    parameter int DIV = RC_DIV               // System clocks per RC tick
) (
    input wire logic aclk,               // System clock, 10 MHz
    input wire logic aresetn,            // Synchronous reset, active low
    input wire logic stop_mode,          // Processor is in stop mode
    input wire logic wait_mode,          // Processor is in wait mode
    input wire logic [7:0] port_a_pins,  // Port A pin levels, bits 5:0 used
    input wire logic [7:0] awaddr,       // Write address
    input wire logic awvalid,            // Write address valid
    output logic awready,                // Write address ready
    input wire logic [31:0] wdata,       // Write data
    input wire logic [3:0] wstrb,        // Write strobes
    input wire logic wvalid,             // Write data valid
    output logic wready,                 // Write data ready
    output logic [1:0] bresp,            // Write response
    output logic bvalid,                 // Write response valid
    input wire logic bready,             // Write response ready
    input wire logic [7:0] araddr,       // Read address
    input wire logic arvalid,            // Read address valid
    output logic arready,                // Read address ready
    output logic [31:0] rdata,           // Read data
    output logic [1:0] rresp,            // Read response
    output logic rvalid,                 // Read valid
    input wire logic rready,             // Read ready
    output logic keyboard_interrupt,     // Request on keyboard vector
    output logic irq                     // Masked sticky event interrupt
);
    if (DIV < 1 || DIV > 2**16 || SHORT_COUNT < 2 ||
        LONG_COUNT < SHORT_COUNT || LONG_COUNT > 2**24 - 1) begin : g_bad_cfg
        $error("awu_timer: unsupported parameters");
    end

    localparam logic [23:0] LONG_C = 24'(LONG_COUNT - 1);
    localparam logic [23:0] SHORT_C = 24'(SHORT_COUNT - 1);
    localparam logic [15:0] DIV_C = 16'(DIV - 1);
    default clocking dflt_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic wakeup_irq_enable_reg;
    logic watchdog_rate_select_reg;
    logic keyboard_irq_mask_reg;
    logic wakeup_latch_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic [7:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg;
    logic [2:0] stop_sync_reg, wait_sync_reg;
    logic stop_reg, wait_reg, stop_prev_reg;
    logic [15:0] div_reg;
    logic [23:0] count_reg;
    logic rc_tick, run, stop_entry, wakeup_request, ack_write;
    logic [7:0] aw_addr_reg;
    logic aw_held_reg, w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_fire;

    // Three-stage sync; a change counts once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_sync_reg <= 3'h0;
            wait_sync_reg <= 3'h0;
            stop_reg <= 1'b0;
            wait_reg <= 1'b0;
            pin_s1_reg <= 8'h00;
            pin_s2_reg <= 8'h00;
            pin_s3_reg <= 8'h00;
            pin_reg <= 8'h00;
        end else begin
            stop_sync_reg <= {stop_sync_reg[1:0], stop_mode};
            wait_sync_reg <= {wait_sync_reg[1:0], wait_mode};
            pin_s1_reg <= port_a_pins;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            if (stop_sync_reg[1] == stop_sync_reg[2]) begin
                stop_reg <= stop_sync_reg[2];
            end
            if (wait_sync_reg[1] == wait_sync_reg[2]) begin
                wait_reg <= wait_sync_reg[2];
            end
            for (int i = 0; i < 8; i++) begin
                if (pin_s2_reg[i] == pin_s3_reg[i]) begin
                    pin_reg[i] <= pin_s3_reg[i];
                end
            end
        end
    end

    assign stop_entry = stop_reg && !stop_prev_reg;
    // Wait mode never runs the generator, even if stop is also flagged
    assign run = stop_reg && !wait_reg && wakeup_irq_enable_reg; // RULE_01 RULE_03

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_prev_reg <= 1'b0;
        end else begin
            stop_prev_reg <= stop_reg;
        end
    end

    // Divider stands in for the private RC oscillator: its tick feeds only
    // the generator counter and nothing else in the block
    always_ff @(posedge aclk) begin
        if (!aresetn || !run || stop_entry) begin
            div_reg <= 16'h0000; // RULE_02 RULE_14
        end else if (div_reg == DIV_C) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
    end
    assign rc_tick = run && (div_reg == DIV_C); // RULE_14

    assign wakeup_request = rc_tick &&
        (count_reg == (watchdog_rate_select_reg ? SHORT_C : LONG_C)); // RULE_06

    always_ff @(posedge aclk) begin
        if (!aresetn || !run || stop_entry) begin
            count_reg <= 24'h000000; // RULE_02 RULE_04
        end else if (wakeup_request) begin
            count_reg <= 24'h000000; // RULE_05
        end else if (rc_tick) begin
            count_reg <= count_reg + 24'h000001;
        end
    end

    // Write channel: address and data accepted in either order
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid;
    assign ack_write = wr_fire && aw_addr_reg == CTRL_OFF &&
        w_strb_reg[0] && w_data_reg[CTRL_ACK_BIT];

    // Set beats acknowledge so a request in the ack cycle is kept
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wakeup_latch_reg <= 1'b0; // RULE_11
        end else if (wakeup_request && wakeup_irq_enable_reg) begin
            wakeup_latch_reg <= 1'b1; // RULE_05 RULE_07
        end else if (ack_write) begin
            wakeup_latch_reg <= 1'b0; // RULE_11 RULE_15
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            keyboard_interrupt <= 1'b0;
        end else begin
            keyboard_interrupt <= wakeup_latch_reg && wakeup_irq_enable_reg &&
                !keyboard_irq_mask_reg; // RULE_08 RULE_13 RULE_15
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            awready <= 1'b1;
            wready <= 1'b1;
        end else begin
            if (awvalid && awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
                wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid <= 1'b1;
                case (aw_addr_reg)
                    CTRL_OFF, IRQ_STAT_OFF, IRQ_MASK_OFF: bresp <= RESP_OKAY;
                    STATUS_OFF, PORTA_OFF: bresp <= RESP_OKAY;
                    default: bresp <= RESP_SLVERR;
                endcase
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Port A bit 6 write is dropped: no data, direction or pullup exists
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wakeup_irq_enable_reg <= 1'b0;
            watchdog_rate_select_reg <= 1'b0;
            keyboard_irq_mask_reg <= 1'b0;
            irq_mask_reg <= IRQ_MASK_RST;
        end else if (wr_fire && w_strb_reg[0]) begin
            if (aw_addr_reg == CTRL_OFF) begin
                wakeup_irq_enable_reg <= w_data_reg[CTRL_IE_BIT];
                watchdog_rate_select_reg <= w_data_reg[CTRL_RATE_BIT];
                keyboard_irq_mask_reg <= w_data_reg[CTRL_KMASK_BIT];
            end else if (aw_addr_reg == IRQ_MASK_OFF) begin
                irq_mask_reg <= w_data_reg[1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == EV_WAKE_BIT && wakeup_request &&
                        wakeup_irq_enable_reg) ||
                    (i == EV_ENTRY_BIT && stop_entry)) begin
                    irq_stat_reg[i] <= 1'b1;
                end else if (wr_fire && w_strb_reg[0] &&
                    aw_addr_reg == IRQ_STAT_OFF && w_data_reg[i]) begin
                    irq_stat_reg[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
            arready <= 1'b1;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            arready <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= 32'h00000000;
            case (araddr)
                CTRL_OFF: begin
                    rdata[CTRL_IE_BIT] <= wakeup_irq_enable_reg;
                    rdata[CTRL_RATE_BIT] <= watchdog_rate_select_reg;
                    rdata[CTRL_KMASK_BIT] <= keyboard_irq_mask_reg;
                end
                STATUS_OFF: begin
                    rdata[STAT_LATCH_BIT] <= wakeup_latch_reg;
                    rdata[STAT_RUN_BIT] <= run;
                    rdata[STAT_IRQ_BIT] <= keyboard_interrupt;
                end
                PORTA_OFF: begin
                    rdata[7:0] <= pin_reg & PORTA_IN_MASK; // RULE_10
                    rdata[PORTA_LATCH_BIT] <= wakeup_latch_reg; // RULE_09 RULE_12
                end
                IRQ_STAT_OFF: rdata[1:0] <= irq_stat_reg;
                IRQ_MASK_OFF: rdata[1:0] <= irq_mask_reg;
                default: rresp <= RESP_SLVERR;
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Clocks since the generator last restarted, kept apart from its counter
    logic [31:0] run_cycles;
    always_ff @(posedge aclk) begin
        if (!aresetn || !run || stop_entry || wakeup_request) begin
            run_cycles <= 32'h00000000;
        end else begin
            run_cycles <= run_cycles + 32'h00000001;
        end
    end

    latch_sets_a: assert property ( // RULE_07
        wakeup_request && wakeup_irq_enable_reg |=> wakeup_latch_reg)
        else $error("latch not set on request");
    ack_clears_a: assert property ( // RULE_11
        ack_write && !wakeup_request |=> !wakeup_latch_reg)
        else $error("latch not cleared by ack");
    latch_holds_a: assert property ( // RULE_15
        wakeup_latch_reg && !ack_write |=> wakeup_latch_reg)
        else $error("latch dropped");
    idle_count_a: assert property ( // RULE_02
        !stop_reg ##1 !stop_reg |-> count_reg == 24'h000000)
        else $error("counter runs outside stop");
    wait_idle_a: assert property ( // RULE_03
        wait_reg |-> !wakeup_request)
        else $error("request in wait");
    entry_zero_a: assert property ( // RULE_04
        stop_entry |=> count_reg == 24'h000000)
        else $error("counter not cleared on stop entry");
    wake_period_a: assert property ( // RULE_06
        wakeup_request |-> run_cycles == 32'((watchdog_rate_select_reg ?
            SHORT_COUNT : LONG_COUNT) * DIV - 1))
        else $error("wrong overflow period");
    kbd_irq_a: assert property ( // RULE_08
        wakeup_latch_reg && wakeup_irq_enable_reg && !keyboard_irq_mask_reg
        ##1 $stable(wakeup_irq_enable_reg) |-> keyboard_interrupt)
        else $error("keyboard request missing");
    no_irq_off_a: assert property ( // RULE_08
        !$past(wakeup_irq_enable_reg) |-> !keyboard_interrupt)
        else $error("request while disabled");
    kbd_gated_a: assert property ( // RULE_15
        keyboard_interrupt |-> $past(wakeup_latch_reg) &&
            !$past(keyboard_irq_mask_reg))
        else $error("request without latch or while masked");
    wake_cov: cover property (wakeup_request && wakeup_irq_enable_reg);
    ack_cov: cover property (wakeup_latch_reg ##1 ack_write);
    short_cov: cover property (wakeup_request && watchdog_rate_select_reg);
    reentry_cov: cover property (stop_entry && wakeup_latch_reg);
endmodule : awu_timer

//--- tb/swt_core_model.sv
`timescale 1ns/1ns
module swt_core_model (
    input wire logic aclk,               // System clock
    input wire logic aresetn,            // Reset, active low
    input wire logic cmd_stop,           // Execute a stop
    input wire logic cmd_run,            // Leave stop without a wakeup
    input wire logic keyboard_interrupt, // Keyboard vector request
    output logic stop_mode,              // Core halted in stop
    output logic [7:0] wakes             // Stops ended by the vector
);
    // The keyboard vector or cmd_run ends stop; other sources are not modelled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_mode <= 1'b0;
            wakes <= 8'h00;
        end else if (cmd_stop) begin
            stop_mode <= 1'b1;
        end else if (stop_mode && keyboard_interrupt) begin
            stop_mode <= 1'b0;
            wakes <= wakes + 8'h01;
        end else if (cmd_run) begin
            stop_mode <= 1'b0;
        end
    end
endmodule : swt_core_model

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
    import awu_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, wait_mode = 1'b0, cmd_stop = 1'b0;
    logic cmd_run = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, stop_mode, bvalid, rvalid;
    logic awready, wready, arready, keyboard_interrupt, irq;
    logic [7:0] port_a_pins = 8'hE5, awaddr = 8'h00, araddr = 8'h00, wakes;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, lb, lr;
    int n_errors = 0, num_checks = 0;
    awu_timer #(.LONG_COUNT(8), .SHORT_COUNT(4), .DIV(2)) u_awu_timer (
        .aclk, .aresetn, .stop_mode, .wait_mode, .port_a_pins, .awaddr,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .keyboard_interrupt, .irq);
    swt_core_model u_swt_core_model (.aclk, .aresetn, .cmd_stop, .cmd_run,
        .keyboard_interrupt, .stop_mode, .wakes);
    always #50 aclk = ~aclk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task automatic go(input logic s);
        cmd_stop <= s;
        cmd_run <= !s;
        @(posedge aclk);
        cmd_stop <= 1'b0;
        cmd_run <= 1'b0;
    endtask : go
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        lb = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        lr = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask : rc
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (5000) @(posedge aclk);
        chk(32'h0, 32'h1);
        conclude();
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(STATUS_OFF, 32'h0);
        rc(PORTA_OFF, 32'h25);
        rd(8'h14, v);
        chk({lr, v[29:0]}, {RESP_SLVERR, 30'h0});
        wr(8'h14, 32'h0000000F);
        chk({30'h0, lb}, {30'h0, RESP_SLVERR});
        wr(CTRL_OFF, 32'h7);
        cyc(40);
        rc(STATUS_OFF, 32'h0);
        wait_mode <= 1'b1;
        go(1'b1);
        cyc(30);
        rc(STATUS_OFF, 32'h0);
        wait_mode <= 1'b0;
        go(1'b0);
        cyc(6);
        wr(CTRL_OFF, 32'h6);
        go(1'b1);
        cyc(30);
        rc(STATUS_OFF, 32'h0);
        go(1'b0);
        cyc(6);
        // Keyboard path masked here so the core stays stopped
        wr(CTRL_OFF, 32'h7);
        go(1'b1);
        cyc(25);
        rc(STATUS_OFF, 32'h3);
        chk({31'h0, keyboard_interrupt}, 32'h0);
        rc(PORTA_OFF, 32'h65);
        wr(PORTA_OFF, 32'hFF);
        chk({30'h0, lb}, {30'h0, RESP_OKAY});
        rc(PORTA_OFF, 32'h65);
        go(1'b0);
        cyc(6);
        wr(CTRL_OFF, 32'h6);
        rc(PORTA_OFF, 32'h65);
        wr(CTRL_OFF, 32'hE);
        rc(STATUS_OFF, 32'h0);
        wr(CTRL_OFF, 32'h5);
        go(1'b1);
        cyc(8);
        go(1'b0);
        cyc(6);
        go(1'b1);
        cyc(14);
        rc(STATUS_OFF, 32'h2);
        cyc(12);
        rc(STATUS_OFF, 32'h3);
        aresetn <= 1'b0;
        cyc(2);
        aresetn <= 1'b1;
        cyc(1);
        rc(STATUS_OFF, 32'h0);
        wr(IRQ_MASK_OFF, 32'h3);
        wr(CTRL_OFF, 32'h3);
        go(1'b1);
        while (wakes !== 8'h01)
            @(posedge aclk);
        chk({24'h0, wakes}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(IRQ_MASK_OFF, 32'h0);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        wr(IRQ_STAT_OFF, 32'h3);
        wr(IRQ_MASK_OFF, 32'h3);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, keyboard_interrupt}, 32'h1);
        wr(CTRL_OFF, 32'hB);
        cyc(2);
        chk({31'h0, keyboard_interrupt}, 32'h0);
        conclude();
    end
endmodule : tb
